// File: hw/afpd_top.sv
// Purpose: fan pwm duty control with spin-up and temperature curves
// Assumes: temperatures and fan enable come from logic on mclk; strap is a pin
// Notes: registers sit on a plain byte-wide register port at their offsets
//
// Notes on behaviour
// - strap low selects high range, else low
// - reset frequency code gives 25kHz or 30Hz
// - pwm period counted on 3.2MHz timebase
// - fan start drives full duty for spin-up
// - spin-up disable skips spin-up, ignores time
// - local threshold bits 7:3, 4C steps, 32C
// - local at or below threshold gives floor
// - slope codes 0-4 give 32 down to 2
// - remote threshold same encoding, default 48C
// - remote at or below threshold gives floor
// - remote slope bits 2:0, default 16/C
// - frequency code table per range
// - spin-up code table 0.2s to 8s, 2s default
// - spin-up disable bit clear means enabled
`include "afpd_params.svh"
module afpd_top #(
  parameter int MS_CYCLES = int'(`AFPD_CLK_HZ / `AFPD_MS_PER_S)
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       range_strap,
  input  wire logic       fan_enable,
  input  wire logic       remote_ctrl,
  input  wire logic [7:0] local_temp,
  input  wire logic [7:0] remote_temp,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            pwm_out,
  output logic      [7:0] duty_value,
  output logic            spinup_active
);
  localparam int MS_W = $clog2(MS_CYCLES + 1);

  // register state
  logic [7:0] fan_char_r;
  logic [7:0] low_temp_duty_floor_r;
  logic [7:0] local_fan_curve_ctrl_r;
  logic [7:0] remote_fan_curve_ctrl_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // strap synchroniser
  logic strap_meta_r;
  logic strap_sync_r;

  // spin control
  afpd_pkg::afpd_state_type state_r;
  afpd_pkg::afpd_state_type state_nxt;
  logic [MS_W-1:0] ms_div_r;
  logic [12:0]     ms_left_r;
  logic [12:0]     spin_ms;
  logic            ms_tick;
  logic            spin_done;
  logic [7:0]      duty_nxt;
  logic [7:0]      duty_r;
  logic            spin_act_r;

  // decoded fields
  wire       spinup_disable  = fan_char_r[`AFPD_FC_SPIN_DIS_BIT];
  wire [2:0] pwm_freq_sel    = fan_char_r[`AFPD_FC_FREQ_MSB:`AFPD_FC_FREQ_LSB];
  wire [2:0] spinup_time_sel = fan_char_r[`AFPD_FC_STIME_MSB:`AFPD_FC_STIME_LSB];
  wire       range_hi        = ~strap_sync_r;
  wire       wr_fan_char     = reg_wr && (reg_addr == `AFPD_OFS_FAN_CHAR);
  wire       wr_floor        = reg_wr && (reg_addr == `AFPD_OFS_DUTY_FLOOR);
  wire       wr_local        = reg_wr && (reg_addr == `AFPD_OFS_LOCAL_CURVE);
  wire       wr_remote       = reg_wr && (reg_addr == `AFPD_OFS_REMOTE_CURVE);

  afpd_curve_if local_cv ();
  afpd_curve_if remote_cv ();

  // local curve settings
  assign local_cv.temp       = local_temp;
  assign local_cv.thr_code   = local_fan_curve_ctrl_r[`AFPD_CV_THR_MSB:`AFPD_CV_THR_LSB];
  assign local_cv.slope_sel  = local_fan_curve_ctrl_r[`AFPD_CV_SLOPE_MSB:`AFPD_CV_SLOPE_LSB];
  assign local_cv.floor_duty = low_temp_duty_floor_r;

  // remote curve settings share the floor
  assign remote_cv.temp       = remote_temp;
  assign remote_cv.thr_code   = remote_fan_curve_ctrl_r[`AFPD_CV_THR_MSB:`AFPD_CV_THR_LSB];
  assign remote_cv.slope_sel  = remote_fan_curve_ctrl_r[`AFPD_CV_SLOPE_MSB:`AFPD_CV_SLOPE_LSB];
  assign remote_cv.floor_duty = low_temp_duty_floor_r;

  afpd_duty_calc u_local_calc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cv    (local_cv)
  );

  afpd_duty_calc u_remote_calc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cv    (remote_cv)
  );

  afpd_pwm_gen u_pwm (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .freq_sel (pwm_freq_sel),
    .range_hi (range_hi),
    .duty     (duty_r),
    .pwm_out  (pwm_out)
  );

  // strap is a pin: two flops before use
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_meta_r <= 1'b1;
      strap_sync_r <= 1'b1;
    end else begin
      strap_meta_r <= range_strap;
      strap_sync_r <= strap_meta_r;
    end
  end

  // register writes; reserved bit 6 of fan char stays zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fan_char_r              <= `AFPD_RST_FAN_CHAR;
      low_temp_duty_floor_r   <= `AFPD_RST_DUTY_FLOOR;
      local_fan_curve_ctrl_r  <= `AFPD_RST_LOCAL_CURVE;
      remote_fan_curve_ctrl_r <= `AFPD_RST_REMOTE_CURVE;
    end else begin
      if (wr_fan_char) fan_char_r <= reg_wdata & `AFPD_FC_RSVD_MASK;
      if (wr_floor)    low_temp_duty_floor_r <= reg_wdata;
      if (wr_local)    local_fan_curve_ctrl_r <= reg_wdata;
      if (wr_remote)   remote_fan_curve_ctrl_r <= reg_wdata;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      `AFPD_OFS_FAN_CHAR:     rdata_nxt = fan_char_r;
      `AFPD_OFS_DUTY_FLOOR:   rdata_nxt = low_temp_duty_floor_r;
      `AFPD_OFS_LOCAL_CURVE:  rdata_nxt = local_fan_curve_ctrl_r;
      `AFPD_OFS_REMOTE_CURVE: rdata_nxt = remote_fan_curve_ctrl_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge mclk) begin
    if (!rst_n)      rdata_r <= 8'h00;
    else if (reg_rd) rdata_r <= rdata_nxt;
  end

  // spin-up time table in ms
  always_comb begin
    case (spinup_time_sel)
      3'd0:    spin_ms = `AFPD_SPIN_T0;
      3'd1:    spin_ms = `AFPD_SPIN_T1;
      3'd2:    spin_ms = `AFPD_SPIN_T2;
      3'd3:    spin_ms = `AFPD_SPIN_T3;
      3'd4:    spin_ms = `AFPD_SPIN_T4;
      3'd5:    spin_ms = `AFPD_SPIN_T5;
      3'd6:    spin_ms = `AFPD_SPIN_T6;
      default: spin_ms = `AFPD_SPIN_T7;
    endcase
  end

  assign ms_tick   = (ms_div_r == MS_W'(MS_CYCLES - 1));
  assign spin_done = ms_tick && (ms_left_r == 13'h0001);

  // spin control; disable set mid spin ends spin at once
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      afpd_pkg::AFPD_IDLE: begin
        if (fan_enable) state_nxt = spinup_disable ? afpd_pkg::AFPD_RUN : afpd_pkg::AFPD_SPIN;
      end
      afpd_pkg::AFPD_SPIN: begin
        if (!fan_enable)                     state_nxt = afpd_pkg::AFPD_IDLE;
        else if (spinup_disable || spin_done) state_nxt = afpd_pkg::AFPD_RUN;
      end
      afpd_pkg::AFPD_RUN: begin
        if (!fan_enable) state_nxt = afpd_pkg::AFPD_IDLE;
      end
      default: state_nxt = afpd_pkg::AFPD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) state_r <= afpd_pkg::AFPD_IDLE;
    else        state_r <= state_nxt;
  end

  // millisecond divider runs only while spinning
  always_ff @(posedge mclk) begin
    if (!rst_n || state_r != afpd_pkg::AFPD_SPIN) ms_div_r <= '0;
    else if (ms_tick)                            ms_div_r <= '0;
    else                                          ms_div_r <= ms_div_r + 1'b1;
  end

  // remaining spin time, loaded on start
  always_ff @(posedge mclk) begin
    if (!rst_n)                                ms_left_r <= 13'h0000;
    else if (state_r == afpd_pkg::AFPD_IDLE)   ms_left_r <= spin_ms;
    else if (ms_tick && ms_left_r != 13'h0000) ms_left_r <= ms_left_r - 13'h0001;
  end

  // duty source: off, full during spin, else chosen curve
  assign duty_nxt = (state_r == afpd_pkg::AFPD_IDLE) ? `AFPD_DUTY_ZERO :
                    (state_r == afpd_pkg::AFPD_SPIN) ? `AFPD_DUTY_FULL :
                    remote_ctrl ? remote_cv.duty : local_cv.duty;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      duty_r     <= `AFPD_DUTY_ZERO;
      spin_act_r <= 1'b0;
    end else begin
      duty_r     <= duty_nxt;
      spin_act_r <= (state_r == afpd_pkg::AFPD_SPIN);
    end
  end

  assign reg_rdata     = rdata_r;
  assign duty_value    = duty_r;
  assign spinup_active = spin_act_r;
endmodule : afpd_top

// File: hw/afpd_params.svh
// Purpose: offsets, field positions, reset values and timing figures of the fan duty block
// Assumes: included by bare name from every design file that needs a figure
// Notes: definitions only, guarded against double inclusion
`ifndef AFPD_PARAMS_SVH
`define AFPD_PARAMS_SVH

// register offsets on the register port
`define AFPD_OFS_FAN_CHAR    8'h20
`define AFPD_OFS_DUTY_FLOOR  8'h21
`define AFPD_OFS_LOCAL_CURVE 8'h24
`define AFPD_OFS_REMOTE_CURVE 8'h25

// reset values
`define AFPD_RST_FAN_CHAR     8'h1D
`define AFPD_RST_DUTY_FLOOR   8'h55
`define AFPD_RST_LOCAL_CURVE  8'h41
`define AFPD_RST_REMOTE_CURVE 8'h61

// field positions of the fan characteristics register
`define AFPD_FC_SPIN_DIS_BIT 7
`define AFPD_FC_FREQ_MSB     5
`define AFPD_FC_FREQ_LSB     3
`define AFPD_FC_STIME_MSB    2
`define AFPD_FC_STIME_LSB    0
`define AFPD_FC_RSVD_MASK    8'hBF

// field positions of both curve registers
`define AFPD_CV_THR_MSB   7
`define AFPD_CV_THR_LSB   3
`define AFPD_CV_SLOPE_MSB 2
`define AFPD_CV_SLOPE_LSB 0
`define AFPD_THR_STEP_SHIFT 2

// clock and timebase rates in Hz
`define AFPD_CLK_HZ 32'h02FA_F080
`define AFPD_TB_HZ  32'h0030_D400
`define AFPD_TB_GCD 32'h0006_1A80
`define AFPD_MS_PER_S 32'h0000_03E8

// pwm frequencies in Hz, low range then high range
`define AFPD_LO_F0 32'h0000_000A
`define AFPD_LO_F1 32'h0000_000F
`define AFPD_LO_F2 32'h0000_0017
`define AFPD_LO_F3 32'h0000_001E
`define AFPD_LO_F4 32'h0000_0026
`define AFPD_LO_F5 32'h0000_002F
`define AFPD_LO_F6 32'h0000_003E
`define AFPD_LO_F7 32'h0000_005E
`define AFPD_HI_F0 32'h0000_03E8
`define AFPD_HI_F1 32'h0000_2710
`define AFPD_HI_F2 32'h0000_4E20
`define AFPD_HI_F3 32'h0000_61A8
`define AFPD_HI_F4 32'h0000_7530
`define AFPD_HI_F5 32'h0000_9C40

// spin-up times in ms
`define AFPD_SPIN_T0 13'h00C8
`define AFPD_SPIN_T1 13'h0190
`define AFPD_SPIN_T2 13'h0258
`define AFPD_SPIN_T3 13'h0320
`define AFPD_SPIN_T4 13'h03E8
`define AFPD_SPIN_T5 13'h07D0
`define AFPD_SPIN_T6 13'h0FA0
`define AFPD_SPIN_T7 13'h1F40

`define AFPD_DUTY_FULL 8'hFF
`define AFPD_DUTY_ZERO 8'h00

`endif

// File: hw/afpd_pkg.sv
// Purpose: shared types of the fan duty block
// Assumes: figures live in afpd_params.svh
// Notes: nothing here is imported; use afpd_pkg::name
package afpd_pkg;

  typedef logic [7:0] afpd_byte_type;

  // spin control states, gray along idle -> spin -> run
  typedef enum logic [1:0] {
    AFPD_IDLE = 2'b00,
    AFPD_SPIN = 2'b01,
    AFPD_RUN  = 2'b11
  } afpd_state_type;

endpackage : afpd_pkg

// File: hw/afpd_curve_if.sv
// Purpose: carries one temperature curve between top and duty calculator
// Assumes: one instance per sensor
// Notes: top drives settings and temperature, calculator returns duty
interface afpd_curve_if;
  logic [7:0] temp;
  logic [4:0] thr_code;
  logic [2:0] slope_sel;
  logic [7:0] floor_duty;
  logic [7:0] duty;

  modport cfg  (output temp, output thr_code, output slope_sel, output floor_duty, input duty);
  modport calc (input temp, input thr_code, input slope_sel, input floor_duty, output duty);
endinterface : afpd_curve_if

// File: hw/afpd_duty_calc.sv
// Purpose: duty from floor, low threshold and slope for one sensor
// Assumes: temperature is whole degrees, unsigned
// Notes: result is registered, one cycle behind its inputs
`include "afpd_params.svh"
module afpd_duty_calc (
  input wire logic mclk,
  input wire logic rst_n,
  afpd_curve_if.calc cv
);
  logic [6:0]  thr_deg;
  logic        above;
  logic [7:0]  excess;
  logic [12:0] rise;
  logic [13:0] sum;
  logic [7:0]  duty_nxt;
  logic [7:0]  duty_r;

  // threshold is 4 degrees per code
  assign thr_deg = {cv.thr_code, 2'b00};
  assign above   = cv.temp > {1'b0, thr_deg};
  assign excess  = above ? (cv.temp - {1'b0, thr_deg}) : 8'h00;

  // slope as shift; codes above 100 act as 100
  always_comb begin
    case (cv.slope_sel)
      3'b000:  rise = {excess, 5'b0_0000};
      3'b001:  rise = {1'b0, excess, 4'h0};
      3'b010:  rise = {2'b00, excess, 3'b000};
      3'b011:  rise = {3'b000, excess, 2'b00};
      default: rise = {4'h0, excess, 1'b0};
    endcase
  end

  // at or below threshold the floor stands alone
  assign sum      = {6'b00_0000, cv.floor_duty} + {1'b0, rise};
  assign duty_nxt = (sum > 14'h00FF) ? `AFPD_DUTY_FULL : sum[7:0];

  // register result
  always_ff @(posedge mclk) begin
    if (!rst_n) duty_r <= `AFPD_DUTY_ZERO;
    else        duty_r <= duty_nxt;
  end

  assign cv.duty = duty_r;
endmodule : afpd_duty_calc

// File: hw/afpd_pwm_gen.sv
// Purpose: pwm waveform from an internal 3.2 MHz timebase
// Assumes: mclk rate in AFPD_CLK_HZ; timebase is a fractional divider
// Notes: period counter is not restarted when the frequency code changes; a count past a shrunk period wraps at the next tick
`include "afpd_params.svh"
module afpd_pwm_gen #(
  parameter int PER_W = 19
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] freq_sel,
  input  wire logic       range_hi,
  input  wire logic [7:0] duty,
  output logic            pwm_out
);
  // fractional step: add INC, wrap at DEN, gives 3.2 MHz average
  localparam logic [7:0] TB_INC = 8'(`AFPD_TB_HZ / `AFPD_TB_GCD);
  localparam logic [7:0] TB_DEN = 8'(`AFPD_CLK_HZ / `AFPD_TB_GCD);

  logic [7:0]       acc_r;
  logic [7:0]       acc_sum;
  logic             tb_tick;
  logic [PER_W-1:0] cnt_r;
  logic [PER_W-1:0] period;
  logic [PER_W+7:0] prod;
  logic [PER_W-1:0] on_ticks;
  logic             pwm_nxt;

  function automatic logic [PER_W-1:0] per_of(input logic hi, input logic [2:0] sel);
    logic [31:0] f;
    f = 32'h0000_0001;
    if (hi) begin
      case (sel)
        3'd0:    f = `AFPD_HI_F0;
        3'd1:    f = `AFPD_HI_F1;
        3'd2:    f = `AFPD_HI_F2;
        3'd3:    f = `AFPD_HI_F3;
        3'd4:    f = `AFPD_HI_F4;
        default: f = `AFPD_HI_F5;
      endcase
    end else begin
      case (sel)
        3'd0:    f = `AFPD_LO_F0;
        3'd1:    f = `AFPD_LO_F1;
        3'd2:    f = `AFPD_LO_F2;
        3'd3:    f = `AFPD_LO_F3;
        3'd4:    f = `AFPD_LO_F4;
        3'd5:    f = `AFPD_LO_F5;
        3'd6:    f = `AFPD_LO_F6;
        default: f = `AFPD_LO_F7;
      endcase
    end
    return PER_W'(`AFPD_TB_HZ / f);
  endfunction : per_of

  // timebase and period decode
  assign acc_sum  = acc_r + TB_INC;
  assign tb_tick  = acc_sum >= TB_DEN;
  assign period   = per_of(range_hi, freq_sel);
  assign prod     = duty * period;
  assign on_ticks = prod[PER_W+7:8];
  // full scale is held high so 255 really means always on
  assign pwm_nxt  = (duty == `AFPD_DUTY_FULL) || (cnt_r < on_ticks);

  // fractional accumulator
  always_ff @(posedge mclk) begin
    if (!rst_n)       acc_r <= 8'h00;
    else if (tb_tick) acc_r <= acc_sum - TB_DEN;
    else              acc_r <= acc_sum;
  end

  // period counter, >= guards a shrinking period
  always_ff @(posedge mclk) begin
    if (!rst_n) cnt_r <= '0;
    else if (tb_tick) cnt_r <= (cnt_r >= period - 1'b1) ? '0 : cnt_r + 1'b1;
  end

  // registered output
  always_ff @(posedge mclk) begin
    if (!rst_n) pwm_out <= 1'b0;
    else        pwm_out <= pwm_nxt;
  end
endmodule : afpd_pwm_gen

// File: verif/afpd_top_sva.sv
// Purpose: port-level checker for the fan duty block
// Assumes: MS_CYCLES equals the one given to the checked instance
// Notes: shadows spin disable and floor from the write strobes
module afpd_top_sva #(
  parameter int MS_CYCLES = 2
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       range_strap,
  input wire logic       fan_enable,
  input wire logic       remote_ctrl,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pwm_out,
  input wire logic [7:0] duty_value,
  input wire logic       spinup_active
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPIN_MAX = 8000 * MS_CYCLES + 4;
  logic        spin_dis_r;
  logic [7:0]  floor_r;
  logic [31:0] spin_cnt_r;
  logic        wr_char;
  logic        wr_floor;
  // write decodes feeding the shadows
  assign wr_char  = reg_wr && (reg_addr == 8'h20);
  assign wr_floor = reg_wr && (reg_addr == 8'h21);
  // shadows track writes; counter bounds the longest spin
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      spin_dis_r <= 1'b0;
      floor_r    <= 8'h55;
      spin_cnt_r <= 32'h0000_0000;
    end else begin
      if (wr_char) spin_dis_r <= reg_wdata[7];
      if (wr_floor) floor_r <= reg_wdata;
      spin_cnt_r <= spinup_active ? spin_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_unmapped_read: assert property (reg_rd && !(reg_addr inside {8'h20, 8'h21, 8'h24, 8'h25})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_floor_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h21 |=> reg_rdata == floor_r)
    else $error("floor readback wrong");
  a_rsvd_bit_low: assert property (reg_rd && reg_addr == 8'h20 |=> !reg_rdata[6])
    else $error("reserved bit reads one");
  a_spin_full_duty: assert property (spinup_active |-> duty_value == 8'hFF)
    else $error("spin without full duty");
  a_full_duty_high: assert property (duty_value == 8'hFF [*3] |-> pwm_out)
    else $error("full duty not always high");
  a_fan_off_zero: assert property (!fan_enable [*3] |-> duty_value == 8'h00 && !spinup_active)
    else $error("fan off yet driven");
  a_spin_start: assert property (!fan_enable ##1 (fan_enable && !spin_dis_r) |-> ##[1:3] spinup_active)
    else $error("spin-up did not start");
  a_spin_skipped: assert property (spin_dis_r [*4] |-> !spinup_active)
    else $error("spin-up while disabled");
  a_spin_bound: assert property (spinup_active |-> spin_cnt_r <= 32'(SPIN_MAX))
    else $error("spin-up too long");
  c_spin: cover property ($rose(spinup_active));
  c_floor_rd: cover property (reg_rd && reg_addr == 8'h21);
  c_pwm_rise: cover property ($rose(pwm_out));
endmodule : afpd_top_sva

bind afpd_top afpd_top_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (
  .mclk(mclk), .rst_n(rst_n), .range_strap(range_strap), .fan_enable(fan_enable),
  .remote_ctrl(remote_ctrl), .local_temp(local_temp), .remote_temp(remote_temp),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pwm_out(pwm_out), .duty_value(duty_value), .spinup_active(spinup_active)
);

// File: verif/afpd_fan_model.sv
// Purpose: fan load seen from the pwm pin
// Assumes: pwm is a level sampled on mclk
// Notes: each rising drive edge closes a period; a pure load, drives nothing back
module afpd_fan_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        pwm_in,
  output logic      [31:0] per_clks,
  output logic      [31:0] hi_clks,
  output logic      [31:0] n_rise
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_r;
  logic [31:0] hi_r;
  logic        prev_r;
  // first period after reset is partial, users skip it
  always @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r    <= 32'h0000_0000;
      hi_r     <= 32'h0000_0000;
      prev_r   <= 1'b0;
      per_clks <= 32'h0000_0000;
      hi_clks  <= 32'h0000_0000;
      n_rise   <= 32'h0000_0000;
    end else begin
      prev_r <= pwm_in;
      if (pwm_in && !prev_r) begin
        per_clks <= cnt_r;
        hi_clks  <= hi_r;
        n_rise   <= n_rise + 32'h0000_0001;
        cnt_r    <= 32'h0000_0001;
        hi_r     <= 32'h0000_0001;
      end else begin
        cnt_r <= cnt_r + 32'h0000_0001;
        hi_r  <= hi_r + 32'(pwm_in);
      end
    end
  end
endmodule : afpd_fan_model

// File: verif/testbench.sv
// Purpose: self-checking bench for the fan duty block
// Assumes: short millisecond count so spin-ups stay brief
// Notes: 1 kHz code and full low-range periods are too long to time here
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 2;
  // expected periods in mclk cycles: whole 3.2 MHz ticks times 15.625
  localparam logic [31:0] PER [8] = '{32'h0000_C350, 32'h0000_1388, 32'h0000_09C4, 32'h0000_07D0,
                                      32'h0000_0678, 32'h0000_04E2, 32'h0000_04E2, 32'h0000_04E2};
  localparam logic [31:0] SPIN_MS [3] = '{32'h0000_00C8, 32'h0000_07D0, 32'h0000_1F40};
  localparam logic [7:0]  SPIN_CODE [3] = '{8'h00, 8'h05, 8'h07};
  logic        mclk, rst_n, range_strap, fan_enable, remote_ctrl, reg_wr, reg_rd, pwm_out, spinup_active;
  logic [7:0]  local_temp, remote_temp, reg_addr, reg_wdata, reg_rdata, duty_value;
  logic [31:0] per_clks, hi_clks, n_rise, base;
  int          miscompares, n_tests, k;

  afpd_top #(.MS_CYCLES(MS)) DUT (
    .mclk(mclk), .rst_n(rst_n), .range_strap(range_strap), .fan_enable(fan_enable),
    .remote_ctrl(remote_ctrl), .local_temp(local_temp), .remote_temp(remote_temp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pwm_out(pwm_out), .duty_value(duty_value), .spinup_active(spinup_active)
  );
  afpd_fan_model u_fan (
    .mclk(mclk), .rst_n(rst_n), .pwm_in(pwm_out), .per_clks(per_clks), .hi_clks(hi_clks), .n_rise(n_rise)
  );

  // 50 MHz clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // tolerance compare, an unknown never yields one
  function automatic logic [31:0] near(input logic [31:0] a, input logic [31:0] b, input logic [31:0] tol);
    return (((a > b) ? a - b : b - a) <= tol) ? 32'h0000_0001 : 32'h0000_0000;
  endfunction : near

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  // strobes live one full cycle, released at the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("reg_rdata", {24'h00_0000, reg_rdata}, {24'h00_0000, exp});
  endtask : rd_chk

  // unselected sensor is held hot so a wrong selection shows
  task automatic curve(input logic rem, input logic [7:0] cv, input logic [7:0] fl, input logic [7:0] t,
                       input logic [7:0] ex);
    wr(8'h21, fl);
    wr(rem ? 8'h25 : 8'h24, cv);
    remote_ctrl = rem;
    local_temp  = rem ? 8'hC8 : t;
    remote_temp = rem ? t : 8'hC8;
    idle(6);
    chk("duty_value", {24'h00_0000, duty_value}, {24'h00_0000, ex});
  endtask : curve

  task automatic wait_rises(input logic [31:0] n);
    base = n_rise;
    k = 0;
    while (n_rise < base + n && k < 60000) begin
      @(negedge mclk);
      k++;
    end
    chk("rise wait", {31'h0, k < 60000}, 32'h0000_0001);
  endtask : wait_rises

  initial begin
    {rst_n, range_strap, fan_enable, remote_ctrl, reg_wr, reg_rd} = 6'b00_0000;
    {local_temp, remote_temp, reg_addr, reg_wdata} = 32'h0000_0000;
    miscompares = 0;
    n_tests = 0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    rd_chk(8'h20, 8'h1D);
    rd_chk(8'h21, 8'h55);
    rd_chk(8'h24, 8'h41);
    rd_chk(8'h25, 8'h61);
    wr(8'h22, 8'hA5);
    rd_chk(8'h22, 8'h00);
    wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'hBF);
    $display("registers done");
    wr(8'h20, 8'h98);
    fan_enable = 1'b1;
    curve(1'b0, 8'h41, 8'h55, 8'h20, 8'h55);
    curve(1'b0, 8'h41, 8'h55, 8'h21, 8'h65);
    curve(1'b0, 8'h41, 8'h55, 8'h32, 8'hFF);
    for (int s = 0; s < 8; s++) curve(1'b0, 8'(s), 8'h10, 8'h01, 8'h10 + ((s < 5) ? 8'(32 >> s) : 8'h02));
    curve(1'b0, 8'hF9, 8'h20, 8'h7C, 8'h20);
    curve(1'b0, 8'hF9, 8'h20, 8'h7D, 8'h30);
    curve(1'b0, 8'h41, 8'hFF, 8'h00, 8'hFF);
    curve(1'b1, 8'h61, 8'h55, 8'h30, 8'h55);
    curve(1'b1, 8'h61, 8'h55, 8'h31, 8'h65);
    curve(1'b1, 8'hFC, 8'h40, 8'h7D, 8'h42);
    $display("curves done");
    curve(1'b0, 8'h41, 8'h80, 8'h00, 8'h80);
    for (int c = 1; c < 8; c++) begin
      wr(8'h20, 8'h80 | 8'(c << 3));
      wait_rises(32'h0000_0003);
      chk("period", near(per_clks, PER[c], 32'h0000_0010), 32'h0000_0001);
      chk("high time", near(hi_clks, PER[c] >> 1, 32'h0000_0014), 32'h0000_0001);
    end
    range_strap = 1'b1;
    idle(4);
    wr(8'h20, 8'hB8);
    base = n_rise;
    idle(6000);
    chk("low range", near(n_rise, base, 32'h0000_0001), 32'h0000_0001);
    range_strap = 1'b0;
    $display("pwm done");
    for (int i = 0; i < 3; i++) begin
      fan_enable = 1'b0;
      wr(8'h20, 8'h18 | SPIN_CODE[i]);
      fan_enable = 1'b1;
      idle(3);
      k = 0;
      while (spinup_active === 1'b1 && k < 20000) begin
        idle(1);
        k++;
      end
      chk("spin cycles", near(32'(k + 3), SPIN_MS[i] * MS, 32'h0000_0004), 32'h0000_0001);
      idle(4);
      chk("duty_value", {24'h00_0000, duty_value}, 32'h0000_0080);
    end
    fan_enable = 1'b0;
    wr(8'h20, 8'h1F);
    fan_enable = 1'b1;
    idle(50);
    chk("spinup_active", {31'h0, spinup_active}, 32'h0000_0001);
    wr(8'h20, 8'h9F);
    idle(3);
    chk("spinup_active", {31'h0, spinup_active}, 32'h0000_0000);
    $display("spin-up done");
    close_out();
  end

  // watchdog: slowest period waits plus the 8 s spin-up, with margin, still under the run budget
  initial begin
    repeat (98000) @(posedge mclk);
    miscompares++;
    close_out();
  end
endmodule : testbench
